// File: rtl/rsc_map.svh
// Constants and field layout of the Reed-Solomon stream port logic
// Functional notes
// - Device drives sink_accept to pace upstream
// - Input beat sampled on the transfer edge
// - Beat taken only when offer and accept
// - sink_word ignored while sink_offer low
// - source_offer high exactly when output valid
// - With backpressure, advance on downstream_accept or while source_offer low
// - source_offer low while no new output
// - Corrected symbols leave in arrival order
// - corrected_count is ceil(log2(R+1)) bits wide
// - Count, failure, word merged into source_bundle
// - Lane offers masked while sink_offer low
// - Split code 0 one lane, 2 four
// - Master source_offer when any lane offers
// - Fracturable output bus packs all lane fields
// - Per-lane failure, first, last outputs, four bits
// - lane_fix_count reports errors, twelve bits
// - Everything runs on rising clock edge
// - Reset asynchronous assert, synchronous release; the flops here also release asynchronously, with no synchronizer
// - Input ready latency is zero
// - Encoder output six cycles after accept
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
`define RSC_ENC_LATENCY 6
`define RSC_DEF_P 3
`define RSC_DEF_M 8
`define RSC_DEF_R 16
`define RSC_SKID_SLOTS 2
`define RSC_LANES 4
`define RSC_FR_SYM_W 320
`define RSC_FR_SLICE_W 80
`define RSC_FR_LANE_LSB 320
`define RSC_FR_MODE_LSB 324
`define RSC_FR_ALIGN_BIT 326
`define RSC_FR_IN_W 327
`define RSC_FR_OUT_W 350
`define RSC_FR_CNT_W 12
`define RSC_MODE_W 2
`define RSC_MODE_100G 2'h0
`define RSC_MODE_50G 2'h1
`define RSC_MODE_25G 2'h2
`define RSC_MODE_BAD 2'h3
`endif

// File: rtl/rsc_pkg.sv
// Types shared by the Reed-Solomon stream port modules
`include "rsc_map.svh"
package rsc_pkg;
    typedef enum logic [`RSC_MODE_W-1:0] {
        RSC_SPLIT_1X = `RSC_MODE_100G,
        RSC_SPLIT_2X = `RSC_MODE_50G,
        RSC_SPLIT_4X = `RSC_MODE_25G,
        RSC_SPLIT_BAD = `RSC_MODE_BAD
    } rsc_split_t;
    typedef logic [`RSC_LANES-1:0] rsc_lanes_t;
    typedef logic [`RSC_FR_CNT_W-1:0] rsc_fix_cnt_t;
endpackage

// File: rtl/rsc_beat_if.sv
// Valid/ready beat carrier between the skid stage and the pipeline
`timescale 1ns/1ns
`default_nettype none
interface rsc_beat_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: rtl/rsc_skid.sv
// Two-slot input stage giving a registered sink_accept
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.svh"
module rsc_skid #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic offer,
    input wire logic [W-1:0] word,
    input wire logic hold,
    output logic accept,
    rsc_beat_if.src out
);
    import rsc_pkg::*;

    logic [1:0] count_ff;
    logic [1:0] nxt_count;
    logic accept_ff;
    logic nxt_accept;
    logic [W-1:0] slot0_ff;
    logic [W-1:0] slot1_ff;
    logic take;
    logic pop;
    logic wr0;
    logic wr1;
    logic shift;

    // Content is looked at only on a real transfer, so idle words never land
    assign take = offer & accept_ff;
    assign pop = out.valid & out.ready;
    assign wr0 = take & ((count_ff == 2'h0) | ((count_ff == 2'h1) & pop));
    assign wr1 = take & (count_ff == 2'h1) & ~pop;
    assign shift = pop & (count_ff == 2'h2);
    assign nxt_count = 2'(count_ff + {1'b0, take} - {1'b0, pop});
    // Two slots let accept be a flip-flop yet keep one beat per cycle:
    // a beat can always land even if the pipeline stalls that same cycle
    assign nxt_accept = (nxt_count < 2'(`RSC_SKID_SLOTS)) & ~hold;
    assign accept = accept_ff;
    assign out.valid = (count_ff != 2'h0);
    assign out.data = slot0_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_ff <= 2'h0;
            accept_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            accept_ff <= nxt_accept;
        end
    end

    always_ff @(posedge clk) begin
        if (shift) begin
            slot0_ff <= slot1_ff;
        end else if (wr0) begin
            slot0_ff <= word;
        end
        if (wr1) begin
            slot1_ff <= word;
        end
    end
endmodule
`default_nettype wire

// File: rtl/rsc_lane_map.sv
// Lane qualification of a fracturable input beat
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.svh"
module rsc_lane_map (
    input wire logic offer,
    input wire logic [`RSC_FR_IN_W-1:0] word,
    output logic [`RSC_FR_IN_W-1:0] beat
);
    import rsc_pkg::*;

    rsc_lanes_t lanes_raw;
    rsc_lanes_t lanes_live;
    rsc_split_t split;
    logic [`RSC_LANES-1:0] slice_ok;

    assign lanes_raw = word[`RSC_FR_LANE_LSB +: `RSC_LANES];
    assign split = rsc_split_t'(word[`RSC_FR_MODE_LSB +: `RSC_MODE_W]);
    assign lanes_live = lanes_raw & {`RSC_LANES{offer}};

    // Code 1 is taken as two half-rate lanes; code 3 qualifies nothing
    genvar q;
    generate
        for (q = 0; q < `RSC_LANES; q++) begin : g_slice
            assign slice_ok[q] = (split == RSC_SPLIT_1X) ? lanes_live[0] :
                                 (split == RSC_SPLIT_2X) ? lanes_live[q/2] :
                                 (split == RSC_SPLIT_4X) ? lanes_live[q] : 1'b0;
            assign beat[q*`RSC_FR_SLICE_W +: `RSC_FR_SLICE_W] =
                word[q*`RSC_FR_SLICE_W +: `RSC_FR_SLICE_W] & {`RSC_FR_SLICE_W{slice_ok[q]}};
        end
    endgenerate

    assign beat[`RSC_FR_LANE_LSB +: `RSC_LANES] = lanes_live;
    assign beat[`RSC_FR_MODE_LSB +: `RSC_MODE_W] = word[`RSC_FR_MODE_LSB +: `RSC_MODE_W];
    assign beat[`RSC_FR_ALIGN_BIT] = word[`RSC_FR_ALIGN_BIT] & offer;
endmodule
`default_nettype wire

// File: rtl/rsc_stream_ports.sv
// Streaming sink/source port logic around a Reed-Solomon codec core
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.svh"
module rsc_stream_ports #(
    parameter int P = `RSC_DEF_P,
    parameter int M = `RSC_DEF_M,
    parameter int R = `RSC_DEF_R,
    parameter int LATENCY = `RSC_ENC_LATENCY,
    parameter bit BACKPRESSURE = 1'b0,
    parameter bit FRACT = 1'b0,
    localparam int DW = P * M,
    localparam int CW = $clog2(R + 1),
    localparam int IW = FRACT ? `RSC_FR_IN_W : DW,
    localparam int OW = FRACT ? `RSC_FR_OUT_W : (CW + 1 + DW)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sink_offer,
    input wire logic [IW-1:0] sink_word,
    output logic sink_accept,
    input wire logic core_hold,
    input wire logic [DW-1:0] core_err_value,
    input wire rsc_pkg::rsc_fix_cnt_t core_fix_count,
    input wire rsc_pkg::rsc_lanes_t core_lane_fail,
    input wire rsc_pkg::rsc_lanes_t core_lane_first,
    input wire rsc_pkg::rsc_lanes_t core_lane_last,
    input wire logic downstream_accept,
    output logic source_offer,
    output logic [OW-1:0] source_bundle,
    output logic [DW-1:0] corrected_word,
    output logic [CW-1:0] corrected_count,
    output logic uncorrectable_flag,
    output rsc_pkg::rsc_lanes_t lane_offer_tx,
    output rsc_pkg::rsc_lanes_t lane_uncorrectable,
    output rsc_pkg::rsc_lanes_t lane_packet_first,
    output rsc_pkg::rsc_lanes_t lane_packet_last,
    output rsc_pkg::rsc_fix_cnt_t lane_fix_count,
    output rsc_pkg::rsc_split_t split_select_tx
);
    import rsc_pkg::*;

    // The skid stage adds no cycle after the take edge; the output register takes one
    localparam int DEPTH = (LATENCY > 2) ? (LATENCY - 1) : 1;

    rsc_beat_if #(.W(IW)) beat_if ();

    logic [IW-1:0] in_beat;
    logic adv;
    logic [DEPTH-1:0] pv_ff;
    logic [IW-1:0] pd_ff [DEPTH];
    logic tail_v;
    logic [IW-1:0] tail_d;
    logic [DW-1:0] tail_sym;
    logic [DW-1:0] nxt_word;

    logic nxt_offer;
    logic [OW-1:0] nxt_bundle;
    logic [CW-1:0] nxt_count;
    logic nxt_fail;
    rsc_lanes_t nxt_lanes;
    rsc_lanes_t nxt_lane_fail;
    rsc_lanes_t nxt_first;
    rsc_lanes_t nxt_last;
    rsc_fix_cnt_t nxt_fix;
    rsc_split_t nxt_split;

    logic source_offer_ff;
    logic [OW-1:0] source_bundle_ff;
    logic [DW-1:0] corrected_word_ff;
    logic [CW-1:0] corrected_count_ff;
    logic uncorrectable_ff;
    rsc_lanes_t lane_offer_tx_ff;
    rsc_lanes_t lane_uncorrectable_ff;
    rsc_lanes_t lane_packet_first_ff;
    rsc_lanes_t lane_packet_last_ff;
    rsc_fix_cnt_t lane_fix_count_ff;
    rsc_split_t split_select_tx_ff;

    // Input side: fracturable beats are lane-qualified before storage
    generate
        if (FRACT) begin : g_fr_in
            rsc_lane_map u_lane_map (
                .offer(sink_offer),
                .word(sink_word),
                .beat(in_beat)
            );
        end else begin : g_cu_in
            assign in_beat = sink_word;
        end
    endgenerate

    rsc_skid #(.W(IW)) u_skid (
        .clk(clk),
        .rst(rst),
        .offer(sink_offer),
        .word(in_beat),
        .hold(core_hold),
        .accept(sink_accept),
        .out(beat_if.src)
    );

    // Whole chain moves together; without backpressure it never stops,
    // which keeps the encoder delay fixed but drops output on a slow sink
    assign adv = ~BACKPRESSURE | ~source_offer_ff | downstream_accept;
    assign beat_if.ready = adv;

    genvar s;
    generate
        for (s = 0; s < DEPTH; s++) begin : g_pipe
            logic stage_v;
            logic [IW-1:0] stage_d;
            if (s == 0) begin : g_head
                assign stage_v = beat_if.valid;
                assign stage_d = beat_if.data;
            end else begin : g_body
                assign stage_v = pv_ff[s-1];
                assign stage_d = pd_ff[s-1];
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pv_ff[s] <= 1'b0;
                end else if (adv) begin
                    pv_ff[s] <= stage_v;
                end
            end
            // Data order is a plain shift, so beats leave as they came
            always_ff @(posedge clk) begin
                if (adv) begin
                    pd_ff[s] <= stage_d;
                end
            end
        end
    endgenerate

    assign tail_v = pv_ff[DEPTH-1];
    assign tail_d = pd_ff[DEPTH-1];
    assign tail_sym = tail_d[DW-1:0];
    assign nxt_word = tail_sym ^ core_err_value;

    // Output side field selection
    generate
        if (FRACT) begin : g_fr_out
            rsc_lanes_t t_lanes;
            logic t_align;
            assign t_lanes = tail_d[`RSC_FR_LANE_LSB +: `RSC_LANES];
            assign t_align = tail_d[`RSC_FR_ALIGN_BIT];
            assign nxt_lanes = t_lanes & {`RSC_LANES{tail_v}};
            assign nxt_offer = |nxt_lanes;
            assign nxt_split = rsc_split_t'(tail_d[`RSC_FR_MODE_LSB +: `RSC_MODE_W]);
            assign nxt_lane_fail = core_lane_fail & nxt_lanes;
            // An alignment beat restarts every live lane at a codeword start
            assign nxt_first = (core_lane_first | (t_lanes & {`RSC_LANES{t_align}})) & nxt_lanes;
            assign nxt_last = core_lane_last & nxt_lanes;
            assign nxt_fix = core_fix_count;
            assign nxt_fail = |nxt_lane_fail;
            assign nxt_count = CW'(core_fix_count);
            assign nxt_bundle = {nxt_fix, nxt_lane_fail, nxt_last, nxt_first,
                                 nxt_split, nxt_lanes, nxt_word};
        end else begin : g_cu_out
            assign nxt_offer = tail_v;
            assign nxt_lanes = {{(`RSC_LANES-1){1'b0}}, tail_v};
            assign nxt_split = RSC_SPLIT_1X;
            assign nxt_lane_fail = core_lane_fail & nxt_lanes;
            assign nxt_first = core_lane_first & nxt_lanes;
            assign nxt_last = core_lane_last & nxt_lanes;
            assign nxt_fix = core_fix_count;
            assign nxt_fail = core_lane_fail[0] & tail_v;
            assign nxt_count = CW'(core_fix_count);
            assign nxt_bundle = {nxt_count, nxt_fail, nxt_word};
        end
    endgenerate

    // An empty tail loads a zero offer, so gaps show as low source_offer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            source_offer_ff <= 1'b0;
            lane_offer_tx_ff <= '0;
            lane_uncorrectable_ff <= '0;
            lane_packet_first_ff <= '0;
            lane_packet_last_ff <= '0;
            uncorrectable_ff <= 1'b0;
        end else if (adv) begin
            source_offer_ff <= nxt_offer;
            lane_offer_tx_ff <= nxt_lanes;
            lane_uncorrectable_ff <= nxt_lane_fail;
            lane_packet_first_ff <= nxt_first;
            lane_packet_last_ff <= nxt_last;
            uncorrectable_ff <= nxt_fail;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            source_bundle_ff <= '0;
            corrected_word_ff <= '0;
            corrected_count_ff <= '0;
            lane_fix_count_ff <= '0;
            split_select_tx_ff <= RSC_SPLIT_1X;
        end else if (adv) begin
            source_bundle_ff <= nxt_bundle;
            corrected_word_ff <= nxt_word;
            corrected_count_ff <= nxt_count;
            lane_fix_count_ff <= nxt_fix;
            split_select_tx_ff <= nxt_split;
        end
    end

    assign source_offer = source_offer_ff;
    assign source_bundle = source_bundle_ff;
    assign corrected_word = corrected_word_ff;
    assign corrected_count = corrected_count_ff;
    assign uncorrectable_flag = uncorrectable_ff;
    assign lane_offer_tx = lane_offer_tx_ff;
    assign lane_uncorrectable = lane_uncorrectable_ff;
    assign lane_packet_first = lane_packet_first_ff;
    assign lane_packet_last = lane_packet_last_ff;
    assign lane_fix_count = lane_fix_count_ff;
    assign split_select_tx = split_select_tx_ff;
endmodule
`default_nettype wire

// File: verification/rsc_down_model.sv
// Downstream sink model that takes every output beat or only one in four
`timescale 1ns/1ns
`default_nettype none
module rsc_down_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    output logic downstream_accept
);
    logic [1:0] phase_ff;
    logic acc_ff;
    // Registered so the answer moves just after an edge, as real logic would
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_ff <= 2'h0;
            acc_ff <= 1'b0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
            acc_ff <= !slow || (phase_ff == 2'h2);
        end
    end
    assign downstream_accept = acc_ff;
endmodule
`default_nettype wire

// File: verification/rsc_ports_chk_properties.sv
// Concurrent checks on the stream port pins
`timescale 1ns/1ns
`default_nettype none
module rsc_ports_chk #(
    parameter int P = 3,
    parameter int M = 8,
    parameter int R = 16,
    parameter bit FRACT = 1'b0,
    localparam int DW = P * M,
    localparam int CW = $clog2(R + 1),
    localparam int OW = FRACT ? 350 : (CW + 1 + DW)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sink_offer,
    input wire logic sink_accept,
    input wire logic core_hold,
    input wire rsc_pkg::rsc_fix_cnt_t core_fix_count,
    input wire logic downstream_accept,
    input wire logic source_offer,
    input wire logic [OW-1:0] source_bundle,
    input wire logic [DW-1:0] corrected_word,
    input wire logic [CW-1:0] corrected_count,
    input wire logic uncorrectable_flag,
    input wire rsc_pkg::rsc_lanes_t lane_offer_tx
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic taken;
    logic idle;
    assign taken = sink_offer && sink_accept;
    // Idle with a willing sink, so nothing can be parked in the skid stage
    assign idle = !taken && downstream_accept;
    // The fracturable bundle carries lane fields this checker cannot see
    if (!FRACT) begin : g_cu_merge
        AST_BUNDLE_MERGE:
            assert property (source_bundle == {corrected_count, uncorrectable_flag, corrected_word})
            else $error("bundle differs from its fields");
    end
    AST_COUNT_LOAD:
        assert property ((!source_offer || downstream_accept) ##1 source_offer
            |-> corrected_count == $past(core_fix_count[CW-1:0])) else $error("count not from core");
    AST_STALL_HOLD:
        assert property (source_offer && !downstream_accept |=> source_offer && $stable(source_bundle))
        else $error("output moved while stalled");
    if (!FRACT) begin : g_cu_lanes
        AST_LANE_MASTER:
            assert property ((source_offer == lane_offer_tx[0]) && (lane_offer_tx[3:1] == 3'h0))
            else $error("lane offers disagree with master");
    end
    AST_LANE_ANY:
        assert property (source_offer == (|lane_offer_tx)) else $error("master offer not OR of lanes");
    AST_FAIL_QUAL:
        assert property (uncorrectable_flag |-> source_offer) else $error("failure without output");
    AST_HOLD_REFUSE:
        assert property (core_hold |=> !sink_accept) else $error("accept high after hold");
    AST_LATENCY:
        assert property (idle [*8] ##1 taken ##1 downstream_accept [*6] |=> source_offer)
        else $error("output not six edges after take");
    AST_IDLE_LOW:
        assert property (idle [*8] ##1 idle [*3] |-> !source_offer) else $error("offer without data");
    cover property (source_offer && !downstream_accept);
    cover property (taken ##1 taken ##1 taken);
    cover property (core_hold ##1 (sink_offer && !sink_accept));
endmodule
`default_nettype wire
bind rsc_stream_ports rsc_ports_chk #(.P(P), .M(M), .R(R), .FRACT(FRACT)) u_chk (.clk(clk), .rst(rst),
    .sink_offer(sink_offer), .sink_accept(sink_accept), .core_hold(core_hold),
    .core_fix_count(core_fix_count), .downstream_accept(downstream_accept),
    .source_offer(source_offer), .source_bundle(source_bundle), .corrected_word(corrected_word),
    .corrected_count(corrected_count), .uncorrectable_flag(uncorrectable_flag),
    .lane_offer_tx(lane_offer_tx));

// File: verification/tb_rs_stream_codec_ports.sv
// Self-checking bench for the stream port logic with backpressure on
`timescale 1ns/1ns
`default_nettype none
module tb_rs_stream_codec_ports;
    import rsc_pkg::*;
    localparam int DW = 24;
    localparam int CW = 5;
    logic clk = 1'b0, rst = 1'b1, sink_offer = 1'b0, core_hold = 1'b0, slow = 1'b0;
    logic [DW-1:0] sink_word = 24'h0, core_err_value = 24'h0;
    rsc_fix_cnt_t core_fix_count = 12'h0;
    rsc_lanes_t core_lane_fail = 4'h0, core_lane_first = 4'h0, core_lane_last = 4'h0;
    logic downstream_accept, sink_accept, source_offer, uncorrectable_flag;
    logic [CW+DW:0] source_bundle;
    logic [DW-1:0] corrected_word;
    logic [CW-1:0] corrected_count;
    rsc_lanes_t lane_offer_tx, lane_uncorrectable, lane_packet_first, lane_packet_last;
    rsc_fix_cnt_t lane_fix_count;
    rsc_split_t split_select_tx;
    logic fr_offer = 1'b0, fr_accept, fr_src_offer;
    logic [326:0] fr_word = 327'h0;
    logic [349:0] fr_bundle;
    int n_fail = 0, cmp_count = 0, refused = 0;
    logic [DW-1:0] exp_q[$];
    always #5 clk = ~clk;
    rsc_stream_ports #(.BACKPRESSURE(1'b1)) dut (
        .clk(clk), .rst(rst), .sink_offer(sink_offer), .sink_word(sink_word), .sink_accept(sink_accept),
        .core_hold(core_hold), .core_err_value(core_err_value), .core_fix_count(core_fix_count),
        .core_lane_fail(core_lane_fail), .core_lane_first(core_lane_first), .core_lane_last(core_lane_last),
        .downstream_accept(downstream_accept), .source_offer(source_offer), .source_bundle(source_bundle),
        .corrected_word(corrected_word), .corrected_count(corrected_count),
        .uncorrectable_flag(uncorrectable_flag), .lane_offer_tx(lane_offer_tx),
        .lane_uncorrectable(lane_uncorrectable), .lane_packet_first(lane_packet_first),
        .lane_packet_last(lane_packet_last), .lane_fix_count(lane_fix_count),
        .split_select_tx(split_select_tx));
    rsc_down_model u_down (.clk(clk), .rst(rst), .slow(slow), .downstream_accept(downstream_accept));
    // Fracturable build: only the bundle and its offer latency are judged, the bundle holds every lane field
    rsc_stream_ports #(.P(32), .M(10), .BACKPRESSURE(1'b1), .FRACT(1'b1)) dut_fr (
        .clk(clk), .rst(rst), .sink_offer(fr_offer), .sink_word(fr_word), .sink_accept(fr_accept),
        .core_hold(core_hold), .core_err_value({40{core_err_value[7:0]}}), .core_fix_count(core_fix_count),
        .core_lane_fail(core_lane_fail), .core_lane_first(core_lane_first), .core_lane_last(core_lane_last),
        .downstream_accept(downstream_accept), .source_offer(fr_src_offer), .source_bundle(fr_bundle),
        .corrected_word(), .corrected_count(), .uncorrectable_flag(), .lane_offer_tx(),
        .lane_uncorrectable(), .lane_packet_first(), .lane_packet_last(), .lane_fix_count(),
        .split_select_tx());
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_wide(input logic [349:0] got, input logic [349:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        n_fail++;
        $display("[ERR] %0t wait for %s ran out", $time, what);
        tally_and_finish();
    endtask
    // Scoreboard: every taken beat must leave once, in order, with the core status present at the edge it leaves
    always @(posedge clk) begin
        if (!rst && sink_offer && sink_accept) exp_q.push_back(sink_word ^ core_err_value);
        if (!rst && source_offer && downstream_accept) begin
            if (exp_q.size() == 0) begin
                chk(1, 0, "output without input");
            end else begin
                chk(corrected_word, exp_q.pop_front(), "word");
                chk(corrected_count, core_fix_count[CW-1:0], "count");
                chk(uncorrectable_flag, core_lane_fail[0], "fail flag");
                chk(lane_uncorrectable, core_lane_fail & 4'h1, "lane fail");
                chk(lane_packet_last, core_lane_last & 4'h1, "lane last");
                chk(lane_packet_first, core_lane_first & 4'h1, "lane first");
                chk(lane_offer_tx, 4'h1, "lane offer");
                chk(lane_fix_count, core_fix_count, "lane count");
                chk(split_select_tx, RSC_SPLIT_1X, "split");
            end
        end
    end
    // Holds the beat until accept is seen high at a rising edge
    task automatic send(input logic [DW-1:0] w);
        int k;
        k = 0;
        sink_offer = 1'b1;
        sink_word = w;
        @(posedge clk);
        while (sink_accept !== 1'b1 && k < 100) begin
            k++;
            @(posedge clk);
        end
        if (k == 100) timeout("accept");
        refused += k;
        @(negedge clk);
    endtask
    task automatic idle();
        sink_offer = 1'b0;
        sink_word = ~sink_word;
    endtask
    task automatic drain();
        int k;
        k = 0;
        idle();
        while (exp_q.size() != 0 && k < 400) begin
            k++;
            @(negedge clk);
        end
        if (k == 400) timeout("drain");
        repeat (10) @(negedge clk);
    endtask
    task automatic t_reset();
        repeat (10) @(negedge clk);
        chk(sink_accept, 0, "accept in reset");
        chk(source_offer, 0, "offer in reset");
        rst = 1'b0;
        @(negedge clk);
        chk(sink_accept, 1, "accept after reset");
        $display("test reset done");
    endtask
    task automatic t_latency();
        int k;
        drain();
        send(24'habcdef);
        idle();
        k = 0;
        while (source_offer !== 1'b1 && k < 20) begin
            k++;
            @(negedge clk);
        end
        if (k == 20) timeout("output");
        chk(k, 6, "latency");
        drain();
        $display("test latency done");
    endtask
    task automatic t_stream();
        for (int i = 0; i < 12; i++) begin
            if (i == 5) begin
                idle();
                @(negedge clk);
            end
            send({i[7:0], 8'h5a, ~i[7:0]});
        end
        send(24'h0000a7);
        drain();
        $display("test stream done");
    endtask
    task automatic t_backpressure();
        slow = 1'b1;
        refused = 0;
        for (int i = 0; i < 16; i++) send({8'hc3, i[15:0]});
        drain();
        chk(refused > 0, 1, "accept dropped when full");
        slow = 1'b0;
        drain();
        $display("test backpressure done");
    endtask
    task automatic t_hold();
        core_hold = 1'b1;
        sink_offer = 1'b1;
        sink_word = 24'h777777;
        repeat (3) @(negedge clk);
        chk(sink_accept, 0, "accept during hold");
        core_hold = 1'b0;
        send(24'h123456);
        drain();
        $display("test hold done");
    endtask
    task automatic t_status();
        core_err_value = 24'h0f00f0;
        core_fix_count = 12'hfe3;
        core_lane_fail = 4'hf;
        core_lane_last = 4'h5;
        core_lane_first = 4'h3;
        for (int i = 0; i < 4; i++) send({4'ha, i[19:0]});
        drain();
        core_lane_fail = 4'h0;
        for (int i = 0; i < 2; i++) send({4'h5, i[19:0]});
        drain();
        $display("test status done");
    endtask
    // One fracturable beat of all-ones symbols; the bundle must show only qualified slices
    task automatic fr_send(input logic [1:0] md, input rsc_lanes_t ln, input logic al, input logic [349:0] exp);
        int k;
        k = 0;
        fr_offer = 1'b1;
        fr_word = {al, md, ln, {320{1'b1}}};
        @(posedge clk);
        while (fr_accept !== 1'b1 && k < 100) begin
            k++;
            @(posedge clk);
        end
        if (k == 100) timeout("fract accept");
        @(negedge clk);
        fr_offer = 1'b0;
        k = 0;
        while (fr_src_offer !== 1'b1 && k < 20) begin
            k++;
            @(negedge clk);
        end
        if (k == 20) timeout("fract output");
        chk(k, 6, "fract latency");
        chk_wide(fr_bundle, exp, "fract bundle");
        repeat (4) @(negedge clk);
    endtask
    task automatic t_fract();
        core_err_value = 24'h0;
        core_fix_count = 12'h0a5;
        core_lane_fail = 4'h6;
        core_lane_first = 4'h1;
        core_lane_last = 4'h4;
        fr_send(2'h2, 4'h5, 1'b1, {12'h0a5, 4'h4, 4'h4, 4'h5, 2'h2, 4'h5, {2{80'h0, {80{1'b1}}}}});
        fr_send(2'h1, 4'h2, 1'b0, {12'h0a5, 4'h2, 4'h0, 4'h0, 2'h1, 4'h2, {160{1'b1}}, 160'h0});
        fr_send(2'h3, 4'h1, 1'b0, {12'h0a5, 4'h0, 4'h0, 4'h1, 2'h3, 4'h1, 320'h0});
        fr_send(2'h0, 4'h1, 1'b0, {12'h0a5, 4'h0, 4'h0, 4'h1, 2'h0, 4'h1, {320{1'b1}}});
        $display("test fract done");
    endtask
    initial begin
        t_reset();
        t_latency();
        t_stream();
        t_backpressure();
        t_hold();
        t_status();
        t_fract();
        tally_and_finish();
    end
endmodule
`default_nettype wire
